// ===== inc/pfs_pkg.sv
// Constants and types shared by the parallel-in, serial-out FIFO block
// Notes on behaviour
// [R1] Empty output low at zero words, blocks reads
// [R2] Almost flag low near empty or near full
// [R3] Almost flag high between one and seven eighths
// [R4] Single mode: chain output shows half-fill, low above half
// [R5] Expansion mode: pulse chain output on last-location write
// [R6] Integrator ties next-word input to a width tap
// [R7] Full output low only at total capacity
// [R8] Half-fill low from just above half capacity
// [R9] Almost flag high from one to seven eighths
// [R10] Empty output high from one stored word
// [R11] Clear pin resets pointers and sets flag levels
// [R12] Full output low ignores further write strobes
// [R13] Eighth-bit tap gives an eight-bit serial word
// [R14] Shift-clock rising edge reads one bit unless empty
// [R15] Count rises per write, falls per finished word
// [R16] Flags update with the triggering write or read
package pfs_pkg;

    // ------------------------------------------------------------
    // Data path and depth
    // ------------------------------------------------------------
    localparam int DATA_W = 9;
    localparam int DEF_DEPTH = 2048;
    localparam int BUF_DEPTH = 8;
    localparam int IDX_W = 4;

    // ------------------------------------------------------------
    // Flag thresholds as fractions of capacity
    // ------------------------------------------------------------
    localparam int ALMOST_DIV = 8;
    localparam int ALMOST_HI_NUM = 7;
    localparam int HALF_DIV = 2;

    // ------------------------------------------------------------
    // Serial width taps: bit index on the serial output
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] TAP_A_BIT = 4'h4;
    localparam logic [IDX_W-1:0] TAP_SEVEN_BIT = 4'h6;
    localparam logic [IDX_W-1:0] TAP_EIGHT_BIT = 4'h7;
    localparam logic [IDX_W-1:0] TAP_NINE_BIT = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int CHAIN_PULSE_NS = 35;
    localparam int CHAIN_PULSE_CYC = (CHAIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CHAIN_CNT_W = 4;

    // ------------------------------------------------------------
    // Reset levels of pins and flags
    // ------------------------------------------------------------
    localparam logic RST_FULL_N = 1'b1;
    localparam logic RST_HALF_N = 1'b1;
    localparam logic RST_ALMOST_N = 1'b0;
    localparam logic RST_EMPTY_N = 1'b0;
    localparam logic [2:0] RST_SYNC_HIGH = 3'h7;
    localparam logic [2:0] RST_SYNC_LOW = 3'h0;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_FETCH,
        RD_SHIFT
    } pfs_rd_e;

endpackage

// ===== inc/pfs_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/10ps
interface pfs_stream_if #(parameter int W = 9) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/pfs_mem.sv
// Word store of the FIFO: one port, registered read data
`timescale 1ns/10ps
module pfs_mem #(
    parameter int W = 9,
    parameter int DEPTH = 2048
) (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] addr_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] store [DEPTH];

    // Array kept outside a state struct so it maps onto block memory
    always_ff @(posedge clk_i) begin
        if (en_i) begin
            if (we_i) begin
                store[addr_i] <= wdata_i;
            end else begin
                rdata_o <= store[addr_i];
            end
        end
    end
endmodule

// ===== rtl/pfs_buf.sv
// Small word FIFO with valid/ready on both sides
`timescale 1ns/10ps
module pfs_buf #(
    parameter int W = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pfs_stream_if.snk in_s,
    pfs_stream_if.src out_s
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW:0] wp;
        logic [PW:0] rp;
    } pfs_buf_s;

    pfs_buf_s r;
    pfs_buf_s next_r;
    logic full;
    logic empty;

    assign full = (r.wp[PW] != r.rp[PW]) && (r.wp[PW-1:0] == r.rp[PW-1:0]);
    assign empty = (r.wp == r.rp);
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = r.mem[r.rp[PW-1:0]];

    always_comb begin
        next_r = r;
        if (in_s.valid && !full) begin
            next_r.mem[r.wp[PW-1:0]] = in_s.data;
            next_r.wp = r.wp + 1'b1;
        end
        if (out_s.ready && !empty) begin
            next_r.rp = r.rp + 1'b1;
        end
        if (rst_i) begin
            next_r.wp = '0;
            next_r.rp = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        r <= next_r;
    end
endmodule

// ===== rtl/pfs_fifo_flags.sv
// Parallel-in, serial-out FIFO with status flags and serial width taps
`timescale 1ns/10ps
module pfs_fifo_flags
    import pfs_pkg::*;
#(
    parameter int DEPTH = DEF_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fifo_clear_pin_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic serial_shift_clock_i,
    input wire logic next_word_select_n_i,
    input wire logic expansion_mode_i,
    output logic write_ready_o,
    output logic empty_indicator_n_o,
    output logic almost_level_flag_n_o,
    output logic full_indicator_n_o,
    output logic chain_out_n_o,
    output logic serial_data_o,
    output logic serial_oe_o,
    output logic width_tap_a_n_o,
    output logic width_tap_seven_n_o,
    output logic width_tap_eight_n_o,
    output logic width_tap_nine_n_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] LOW_EDGE = CW'(DEPTH / ALMOST_DIV);
    localparam logic [CW-1:0] HIGH_EDGE = CW'(DEPTH * ALMOST_HI_NUM / ALMOST_DIV);
    localparam logic [CW-1:0] HALF_EDGE = CW'(DEPTH / HALF_DIV);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        // Pin synchronisers, three stages each
        logic [2:0] clr_sync;
        logic [2:0] w_sync;
        logic [2:0] sck_sync;
        logic [2:0] nr_sync;
        logic [2:0][DATA_W-1:0] d_sync;
        // Agreed pin levels
        logic clr_lvl;
        logic w_lvl;
        logic sck_lvl;
        logic nr_lvl;
        // Set by a strobe fall that found room
        logic armed;
        // Stored words and array pointers, one bit wider than the address
        logic [CW-1:0] count;
        logic [CW-1:0] wr_ptr;
        logic [CW-1:0] rd_ptr;
        // Serial engine
        pfs_rd_e st;
        logic [DATA_W-1:0] shreg;
        logic [IDX_W-1:0] bit_idx;
        // Remaining cycles of the chain pulse
        logic [CHAIN_CNT_W-1:0] chain_cnt;
        // Registered flags, all active low
        logic full_n;
        logic half_n;
        logic almost_n;
        logic empty_n;
    } pfs_state_s;

    pfs_state_s r;
    pfs_state_s next_r;

    // ------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------
    pfs_stream_if #(.W(DATA_W)) buf_in ();
    pfs_stream_if #(.W(DATA_W)) buf_out ();

    logic mem_en;
    logic mem_we;
    logic [AW-1:0] mem_addr;
    logic [DATA_W-1:0] mem_rdata;
    logic [CW-1:0] mem_words;
    logic rd_issue;
    logic push;
    logic word_done;
    logic w_fall;
    logic w_rise;
    logic sck_rise;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Tap outputs: low while the chosen bit stands on the serial line
    function automatic logic tap_n(input pfs_rd_e st, input logic [IDX_W-1:0] idx,
                                   input logic [IDX_W-1:0] k);
        return !((st == RD_SHIFT) && (idx == k));
    endfunction

    // A pin change counts once the last two stages agree
    function automatic logic agreed(input logic [2:0] sync, input logic lvl);
        if (sync[1] == sync[2]) begin
            return sync[2];
        end
        return lvl;
    endfunction

    // Flag levels for a stored count, ordered full, half, almost, empty
    function automatic logic [3:0] level_flags(input logic [CW-1:0] n);
        logic full_n;
        logic half_n;
        logic almost_n;
        logic empty_n;
        full_n = !(n == FULL_CNT); // [R7] [R12]
        half_n = !(n > HALF_EDGE); // [R4] [R8]
        almost_n = (n >= LOW_EDGE) && (n <= HIGH_EDGE); // [R2] [R3] [R9]
        empty_n = (n != '0); // [R1] [R10]
        return {full_n, half_n, almost_n, empty_n};
    endfunction

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    pfs_buf #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i || !r.clr_lvl),
        .in_s(buf_in),
        .out_s(buf_out)
    );

    pfs_mem #(.W(DATA_W), .DEPTH(DEPTH)) u_mem (
        .clk_i(clk_i),
        .en_i(mem_en),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(buf_out.data),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign write_ready_o = buf_in.ready;
    assign empty_indicator_n_o = r.empty_n;
    assign almost_level_flag_n_o = r.almost_n;
    assign full_indicator_n_o = r.full_n;
    // Shared pin: half-fill alone, or expansion pulse toward the next device
    assign chain_out_n_o = expansion_mode_i ? (r.chain_cnt == '0) : r.half_n; // [R4] [R5]
    assign serial_data_o = r.shreg[0];
    // Released at word end so width-expanded devices can share the line
    assign serial_oe_o = (r.st == RD_SHIFT);
    assign width_tap_a_n_o = tap_n(r.st, r.bit_idx, TAP_A_BIT);
    assign width_tap_seven_n_o = tap_n(r.st, r.bit_idx, TAP_SEVEN_BIT); // [R6]
    assign width_tap_eight_n_o = tap_n(r.st, r.bit_idx, TAP_EIGHT_BIT); // [R13]
    assign width_tap_nine_n_o = tap_n(r.st, r.bit_idx, TAP_NINE_BIT); // [R6]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        // --------------------------------------------------------
        // Pin synchronisers
        // --------------------------------------------------------
        next_r.clr_sync = {r.clr_sync[1:0], fifo_clear_pin_n_i};
        next_r.w_sync = {r.w_sync[1:0], write_strobe_n_i};
        next_r.sck_sync = {r.sck_sync[1:0], serial_shift_clock_i};
        next_r.nr_sync = {r.nr_sync[1:0], next_word_select_n_i};
        next_r.d_sync = {r.d_sync[1:0], data_i};
        next_r.clr_lvl = agreed(r.clr_sync, r.clr_lvl);
        next_r.w_lvl = agreed(r.w_sync, r.w_lvl);
        next_r.sck_lvl = agreed(r.sck_sync, r.sck_lvl);
        next_r.nr_lvl = agreed(r.nr_sync, r.nr_lvl);
        w_fall = r.w_lvl && !next_r.w_lvl;
        w_rise = !r.w_lvl && next_r.w_lvl;
        sck_rise = !r.sck_lvl && next_r.sck_lvl;

        // --------------------------------------------------------
        // Parallel write
        // --------------------------------------------------------
        // Qualified at the falling strobe, stored at the rising one
        // A rise that finds the buffer full loses the word; write_ready_o shows the buffer full
        push = 1'b0;
        buf_in.valid = 1'b0;
        buf_in.data = r.d_sync[2];
        if (w_fall) begin
            next_r.armed = r.full_n; // [R12]
        end
        if (w_rise) begin
            next_r.armed = 1'b0;
            if (r.armed && buf_in.ready) begin
                buf_in.valid = 1'b1;
                push = 1'b1;
            end
        end

        // --------------------------------------------------------
        // Memory port
        // --------------------------------------------------------
        // Reads take priority, so the buffer stalls and can fill
        mem_words = r.wr_ptr - r.rd_ptr;
        rd_issue = (r.st == RD_IDLE) && (mem_words != '0);
        buf_out.ready = !rd_issue && (mem_words != FULL_CNT);
        mem_en = 1'b0;
        mem_we = 1'b0;
        mem_addr = r.rd_ptr[AW-1:0];
        // The chain pulse runs down whatever the port does this cycle
        if (r.chain_cnt != '0) begin
            next_r.chain_cnt = r.chain_cnt - 1'b1;
        end
        if (rd_issue) begin
            mem_en = 1'b1;
            next_r.rd_ptr = r.rd_ptr + 1'b1;
        end else if (buf_out.valid && buf_out.ready) begin
            mem_en = 1'b1;
            mem_we = 1'b1;
            mem_addr = r.wr_ptr[AW-1:0];
            next_r.wr_ptr = r.wr_ptr + 1'b1;
            if (expansion_mode_i && (r.wr_ptr[AW-1:0] == LAST_ADDR)) begin
                next_r.chain_cnt = CHAIN_CNT_W'(CHAIN_PULSE_CYC); // [R5]
            end
        end

        // --------------------------------------------------------
        // Serial engine
        // --------------------------------------------------------
        word_done = 1'b0;
        case (r.st)
            RD_IDLE: begin
                if (rd_issue) begin
                    next_r.st = RD_FETCH;
                end
            end
            RD_FETCH: begin
                next_r.shreg = mem_rdata;
                next_r.bit_idx = '0;
                next_r.st = RD_SHIFT;
            end
            RD_SHIFT: begin
                // Edges outside this state are ignored: nothing to read
                if (sck_rise) begin // [R1] [R14]
                    if (!r.nr_lvl) begin
                        word_done = 1'b1; // [R6] [R13]
                        next_r.st = RD_IDLE;
                    end else begin
                        next_r.shreg = {1'b0, r.shreg[DATA_W-1:1]};
                        if (r.bit_idx != TAP_NINE_BIT) begin
                            next_r.bit_idx = r.bit_idx + 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_r.st = RD_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // Stored count and flags
        // --------------------------------------------------------
        // Words still in the input buffer count as stored, so full can come before the array fills
        next_r.count = r.count + CW'(push) - CW'(word_done); // [R15]

        // Flags follow the new count in the same edge
        {next_r.full_n, next_r.half_n, next_r.almost_n, next_r.empty_n} = level_flags(next_r.count); // [R16]

        // --------------------------------------------------------
        // Reset and clear
        // --------------------------------------------------------
        // Clear also empties the input buffer, so words still in flight are lost
        if (rst_i || !r.clr_lvl) begin // [R11]
            next_r.armed = 1'b0;
            next_r.count = '0;
            next_r.wr_ptr = '0;
            next_r.rd_ptr = '0;
            next_r.st = RD_IDLE;
            next_r.shreg = '0;
            next_r.bit_idx = '0;
            next_r.chain_cnt = '0;
            next_r.full_n = RST_FULL_N;
            next_r.half_n = RST_HALF_N;
            next_r.almost_n = RST_ALMOST_N;
            next_r.empty_n = RST_EMPTY_N;
        end
        if (rst_i) begin
            next_r.clr_sync = RST_SYNC_HIGH;
            next_r.w_sync = RST_SYNC_HIGH;
            next_r.sck_sync = RST_SYNC_LOW;
            next_r.nr_sync = RST_SYNC_HIGH;
            next_r.d_sync = '0;
            next_r.clr_lvl = 1'b1;
            next_r.w_lvl = 1'b1;
            next_r.sck_lvl = 1'b0;
            next_r.nr_lvl = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        r <= next_r;
    end
endmodule

// ===== tb/pfs_fifo_flags_asserts.sv
// Port-level assertions for the FIFO flag and serial width block
`timescale 1ns/10ps
module pfs_fifo_flags_asserts
    import pfs_pkg::*;
#(
    parameter int DEPTH = DEF_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fifo_clear_pin_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic serial_shift_clock_i,
    input wire logic next_word_select_n_i,
    input wire logic expansion_mode_i,
    input wire logic write_ready_o,
    input wire logic empty_indicator_n_o,
    input wire logic almost_level_flag_n_o,
    input wire logic full_indicator_n_o,
    input wire logic chain_out_n_o,
    input wire logic serial_data_o,
    input wire logic serial_oe_o,
    input wire logic width_tap_a_n_o,
    input wire logic width_tap_seven_n_o,
    input wire logic width_tap_eight_n_o,
    input wire logic width_tap_nine_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Low cycles of the chain pulse so far; saturates on a stuck pin
    logic [CHAIN_CNT_W-1:0] chain_low_cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i || !expansion_mode_i || chain_out_n_o) begin
            chain_low_cnt <= '0;
        end else if (chain_low_cnt != '1) begin
            chain_low_cnt <= chain_low_cnt + 1'b1;
        end
    end

    reset_levels_a: assert property (disable iff (1'b0) rst_i |=> !empty_indicator_n_o &&
        !almost_level_flag_n_o && full_indicator_n_o && chain_out_n_o && !serial_oe_o)
        else $error("flag levels wrong after reset");
    clear_levels_a: assert property (!fifo_clear_pin_n_i [*6] |=> !empty_indicator_n_o &&
        !almost_level_flag_n_o && full_indicator_n_o && chain_out_n_o && !serial_oe_o)
        else $error("flag levels wrong while clear pin low");
    full_flags_a: assert property (!full_indicator_n_o |-> empty_indicator_n_o &&
        !almost_level_flag_n_o && (expansion_mode_i || !chain_out_n_o))
        else $error("flags disagree with full");
    empty_flags_a: assert property (!empty_indicator_n_o |-> full_indicator_n_o &&
        !almost_level_flag_n_o && (expansion_mode_i || chain_out_n_o))
        else $error("flags disagree with empty");
    read_needs_word_a: assert property (serial_oe_o |-> empty_indicator_n_o)
        else $error("serial output active while empty");
    full_release_a: assert property ($rose(full_indicator_n_o) && fifo_clear_pin_n_i |->
        $fell(serial_oe_o))
        else $error("full released without a finished word");
    empty_entry_a: assert property ($fell(empty_indicator_n_o) && fifo_clear_pin_n_i |->
        $fell(serial_oe_o))
        else $error("empty entered without a finished word");
    chain_pulse_a: assert property (expansion_mode_i && $past(expansion_mode_i) && $rose(chain_out_n_o) |->
        chain_low_cnt == CHAIN_CNT_W'(CHAIN_PULSE_CYC))
        else $error("chain pulse length wrong");
    chain_bound_a: assert property (expansion_mode_i && !chain_out_n_o |->
        chain_low_cnt < CHAIN_CNT_W'(CHAIN_PULSE_CYC))
        else $error("chain pulse too long");

    cover property (expansion_mode_i && $fell(chain_out_n_o));
    cover property (!full_indicator_n_o);
    cover property ($fell(serial_oe_o));
    cover property ($rose(almost_level_flag_n_o));
endmodule

bind pfs_fifo_flags pfs_fifo_flags_asserts #(.DEPTH(DEPTH)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .fifo_clear_pin_n_i(fifo_clear_pin_n_i), .write_strobe_n_i(write_strobe_n_i), .data_i(data_i),
    .serial_shift_clock_i(serial_shift_clock_i), .next_word_select_n_i(next_word_select_n_i),
    .expansion_mode_i(expansion_mode_i), .write_ready_o(write_ready_o),
    .empty_indicator_n_o(empty_indicator_n_o), .almost_level_flag_n_o(almost_level_flag_n_o),
    .full_indicator_n_o(full_indicator_n_o), .chain_out_n_o(chain_out_n_o),
    .serial_data_o(serial_data_o), .serial_oe_o(serial_oe_o), .width_tap_a_n_o(width_tap_a_n_o),
    .width_tap_seven_n_o(width_tap_seven_n_o), .width_tap_eight_n_o(width_tap_eight_n_o),
    .width_tap_nine_n_o(width_tap_nine_n_o));

// ===== tb/pfs_partner_model.sv
// Parallel word writer and serial bit reader facing the FIFO pins
`timescale 1ns/10ps
module pfs_partner_model
    import pfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic serial_data_i,
    input wire logic serial_oe_i,
    output logic write_strobe_n_o,
    output logic [DATA_W-1:0] data_o,
    output logic shift_clock_o
);
    initial begin
        write_strobe_n_o = 1'b1;
        data_o = '0;
        shift_clock_o = 1'b0;
    end

    // Both strobe phases outlast the pin synchronisers; data is inverted once hold has run out
    task automatic write_word(input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        write_strobe_n_o <= 1'b0;
        data_o <= d;
        repeat (4) @(posedge clk_i);
        write_strobe_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        data_o <= ~d;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic shift_edge();
        @(posedge clk_i);
        shift_clock_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        shift_clock_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // Shift clock stays low outside words; bits arrive least significant first
    task automatic read_word(input int nbits, output logic [DATA_W-1:0] w, output logic ok);
        int n;
        w = '0;
        n = 0;
        while (serial_oe_i !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        ok = serial_oe_i;
        for (int k = 0; k < nbits; k++) begin
            @(negedge clk_i);
            w[k] = serial_data_i;
            shift_edge();
        end
    endtask
endmodule

// ===== tb/pfs_fifo_flags_test.sv
// Self-checking bench for the FIFO flag and serial width block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module pfs_fifo_flags_test import pfs_pkg::*;;
    localparam int D = 64;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic clear_n = 1'b1;
    logic exp_mode = 1'b0;
    logic [1:0] tap_sel = 2'h3;
    logic wr_n, shclk, nws, wrdy, empty_n, almost_n, full_n, chain_n, sdata, soe, ta_n, t7_n, t8_n, t9_n;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] w;
    logic ok;
    int nb[4] = '{5, 7, 8, 9};
    int num_errors = 0;
    int samples_checked = 0;
    int chain_lo = 0;

    always #2 clk_i = ~clk_i;

    // Next-word select tied to the chosen width tap
    assign nws = (tap_sel == 2'h0) ? ta_n : (tap_sel == 2'h1) ? t7_n : (tap_sel == 2'h2) ? t8_n : t9_n;

    always @(posedge clk_i) begin
        if (exp_mode && chain_n === 1'b0) begin
            chain_lo <= chain_lo + 1;
        end
    end

    pfs_fifo_flags #(.DEPTH(D)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .fifo_clear_pin_n_i(clear_n),
        .write_strobe_n_i(wr_n), .data_i(wdata), .serial_shift_clock_i(shclk), .next_word_select_n_i(nws),
        .expansion_mode_i(exp_mode), .write_ready_o(wrdy), .empty_indicator_n_o(empty_n),
        .almost_level_flag_n_o(almost_n), .full_indicator_n_o(full_n), .chain_out_n_o(chain_n),
        .serial_data_o(sdata), .serial_oe_o(soe), .width_tap_a_n_o(ta_n), .width_tap_seven_n_o(t7_n),
        .width_tap_eight_n_o(t8_n), .width_tap_nine_n_o(t9_n));

    pfs_partner_model u_part (.clk_i(clk_i), .serial_data_i(sdata), .serial_oe_i(soe),
        .write_strobe_n_o(wr_n), .data_o(wdata), .shift_clock_o(shclk));

    function automatic logic [DATA_W-1:0] pat(input int i);
        return 9'(i) * 9'h025 + 9'h0a3;
    endfunction

    task automatic chk_flags(input int c);
        `CHK("empty", c != 0, empty_n)
        `CHK("almost", c >= D / 8 && c <= 7 * D / 8, almost_n)
        `CHK("full", c != D, full_n)
        if (!exp_mode) `CHK("half", !(c > D / 2), chain_n)
    endtask

    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_flags(0);
        `CHK("ready", 1'b1, wrdy)
        // --------------------------------------------------------
        // Fill to capacity, then one refused write
        // --------------------------------------------------------
        for (int i = 0; i < D; i++) begin
            u_part.write_word(pat(i));
            chk_flags(i + 1);
        end
        u_part.write_word(9'h1ff);
        chk_flags(D);
        // --------------------------------------------------------
        // Drain through every width tap in turn
        // --------------------------------------------------------
        for (int i = 0; i < D; i++) begin
            tap_sel <= 2'(i);
            @(posedge clk_i);
            u_part.read_word(nb[i % 4], w, ok);
            `CHK("word start", 1'b1, ok)
            if (!ok) begin
                summarize();
            end
            `CHK("word bits", pat(i) & (9'h1ff >> (9 - nb[i % 4])), w)
            chk_flags(D - 1 - i);
        end
        u_part.shift_edge();
        `CHK("oe when empty", 1'b0, soe)
        chk_flags(0);
        // --------------------------------------------------------
        // Depth expansion: chain pulse on the last location, then a clear
        // --------------------------------------------------------
        exp_mode <= 1'b1;
        clear_n <= 1'b0;
        repeat (10) @(posedge clk_i);
        clear_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        for (int i = 0; i < D - 1; i++) begin
            u_part.write_word(pat(i));
        end
        `CHK("chain early", 0, chain_lo)
        u_part.write_word(pat(D));
        repeat (12) @(posedge clk_i);
        `CHK("chain pulse", CHAIN_PULSE_CYC, chain_lo)
        chk_flags(D);
        clear_n <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk_flags(0);
        `CHK("oe on clear", 1'b0, soe)
        clear_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        summarize();
    end
endmodule
